// [rtl/result_port_defs.svh]
// Constants of the result output port: widths, depth, reset values.
// Assumes inclusion once per file through the guard below.
`ifndef RESULT_PORT_DEFS_SVH
`define RESULT_PORT_DEFS_SVH
`define RESULT_WIDTH     16
`define RESULT_FIFO_DEPTH 16
`define BYTE_WIDTH       8
`define SERIAL_A_BIT     7
`define SERIAL_B_BIT     8
`define HIGH_FIRST_BIT   14
`define BYTESEL_BIT      15
`define RESULT_RESET     16'h0000
`endif

// [rtl/result_port_pkg.sv]
// Types shared by the result output port and its helpers.
// Assumes result_port_defs.svh is reachable on the include path.
`include "result_port_defs.svh"
package result_port_pkg;
   typedef enum logic [1:0] {
      mode_word,
      mode_byte,
      mode_serial
   } port_mode_t;

   // One pair of results, one for each serial line.
   typedef struct packed {
      logic [`RESULT_WIDTH-1:0] first;
      logic [`RESULT_WIDTH-1:0] second;
   } result_pair_t;

   // Pin group of the shared data lines.
   typedef struct packed {
      logic [`RESULT_WIDTH-1:0] data;
      logic [`RESULT_WIDTH-1:0] oe;
   } pin_drive_t;
endpackage

// [rtl/result_fifo.sv]
// Synchronous FIFO of flip-flops between the converter and the pins.
// Assumes one clock and a synchronous active-high reset.
`include "result_port_defs.svh"
module result_fifo
   import result_port_pkg::*;
#(
   parameter int WIDTH = `RESULT_WIDTH,
   parameter int DEPTH = `RESULT_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   always_comb begin
      next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
      next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// [rtl/pin_sync.sv]
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to clk.
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1, next_stage1, next_sync;

   always_comb begin
      next_stage1 = async_in;
      next_sync   = stage1;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= next_stage1;
         sync_out <= next_sync;
      end
   end
endmodule

// [rtl/result_port.sv]
// Result output port: word, byte and dual serial modes on shared pins.
// Assumes results arrive on clk with valid/ready; host pins are async
// and are oversampled, so host strobes must be much slower than clk.
`include "result_port_defs.svh"

// Summary of operation
// - Select 0: sixteen pins drive result bits only while select and read low.
// - Select 1 with byte-select 1 enters parallel byte mode.
// - Byte mode gives each result on lines 7..0 over two reads, MSB on 7.
// - High-byte-first 1 sends upper byte first, else lower byte first.
// - Select 1 with byte-select 0 enters serial mode.
// - Serial mode: line 7 is serial line A, line 8 serial line B.
// - Reference select high enables internal reference, low disables it.
// - Chip select fall drives serial lines with MSB; clock rise shifts on.
// - Reset during a read clears the output result registers to zero.
module result_port
   import result_port_pkg::*;
#(
   parameter int WIDTH = `RESULT_WIDTH,
   parameter int DEPTH = `RESULT_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] conv_data,
   input  wire logic             conv_valid,
   output logic                  conv_ready,
   input  wire logic             conv_busy,
   output logic                  busy,
   input  wire logic             interface_select,
   input  wire logic             ref_select,
   output logic                  internal_ref_enable,
   input  wire logic             chip_select_n,
   input  wire logic             read_n,
   input  wire logic [WIDTH-1:0] result_bus_in,
   output logic      [WIDTH-1:0] result_bus_out,
   output logic      [WIDTH-1:0] result_bus_oe,
   output logic      [1:0]       mode
);
   localparam int BW = `BYTE_WIDTH;

   // Pin sampling: cs, rd/sclk, mode select, ref select, byte order,
   // byte select. The strobes enter inverted, so that the cleared
   // synchroniser reads as idle and reset release shows no false edge.
   logic [5:0] raw_pins, pins;
   logic       cs_n_s, rd_s, sel_s, ref_s, high_first_s, bsel_s;
   logic       cs_act_s, rd_act_s;
   assign raw_pins = {!chip_select_n, !read_n, interface_select, ref_select,
                      result_bus_in[`HIGH_FIRST_BIT],
                      result_bus_in[`BYTESEL_BIT]};

   pin_sync #(.WIDTH(6)) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in (raw_pins),
      .sync_out (pins)
   );
   assign {cs_act_s, rd_act_s, sel_s, ref_s, high_first_s, bsel_s} = pins;
   assign cs_n_s = !cs_act_s;
   assign rd_s   = !rd_act_s;

   // Queue between converter and pins
   logic [WIDTH-1:0] q_data;
   logic             q_valid, q_ready;

   result_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_data   (conv_data),
      .in_valid  (conv_valid),
      .in_ready  (conv_ready),
      .out_data  (q_data),
      .out_valid (q_valid),
      .out_ready (q_ready)
   );

   port_mode_t cur_mode;
   always_comb begin
      if (!sel_s) begin
         cur_mode = mode_word;
      end else if (bsel_s) begin
         cur_mode = mode_byte;
      end else begin
         cur_mode = mode_serial;
      end
   end

   // Edge history of the synchronised strobes
   logic cs_n_d, rd_d, next_cs_n_d, next_rd_d;
   logic cs_fall, cs_rise, rd_fall, rd_rise;
   assign cs_fall = cs_n_d && !cs_n_s;
   assign cs_rise = !cs_n_d && cs_n_s;
   assign rd_fall = rd_d && !rd_s;
   assign rd_rise = !rd_d && rd_s;

   always_comb begin
      next_cs_n_d = cs_n_s;
      next_rd_d   = rd_s;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cs_n_d <= 1'b1;
         rd_d   <= 1'b1;
      end else begin
         cs_n_d <= next_cs_n_d;
         rd_d   <= next_rd_d;
      end
   end

   // Output state
   logic [WIDTH-1:0] out_word, next_out_word;
   logic [WIDTH-1:0] shift_a, shift_b, next_shift_a, next_shift_b;
   logic             byte_phase, next_byte_phase;
   logic             serial_on, next_serial_on;
   logic             word_on, next_word_on;
   logic [WIDTH-1:0] next_bus_out, next_bus_oe;
   logic             pop, word_pop, serial_pop;
   logic             second_pending, next_second_pending;

   function automatic logic [BW-1:0] pick_byte(input logic [WIDTH-1:0] w,
                                               input logic upper);
      pick_byte = upper ? w[WIDTH-1 -: BW] : w[BW-1:0];
   endfunction

   // An empty queue answers with zero instead of a stale result
   function automatic logic [WIDTH-1:0] head_or_zero(
      input logic             valid,
      input logic [WIDTH-1:0] data
   );
      head_or_zero = valid ? data : '0;
   endfunction

   // Only one mode is active, so at most one side pops per cycle
   assign pop     = word_pop || serial_pop;
   assign q_ready = pop;

   // Word and byte reads
   always_comb begin
      next_out_word   = out_word;
      next_byte_phase = byte_phase;
      next_word_on    = word_on;
      word_pop        = 1'b0;

      case (cur_mode)
         mode_word: begin
            // A read strobe fetches one word from the queue
            if (!cs_n_s && rd_fall) begin
               next_out_word = head_or_zero(q_valid, q_data);
               word_pop      = q_valid;
               next_word_on  = 1'b1;
            end
            if (cs_n_s || rd_s) begin
               next_word_on = 1'b0;
            end
         end
         mode_byte: begin
            // Limitation: an odd read count drops the unread half
            if (!cs_n_s && rd_fall) begin
               if (!byte_phase) begin
                  next_out_word = head_or_zero(q_valid, q_data);
                  word_pop      = q_valid;
               end
               next_word_on = 1'b1;
            end
            if (!cs_n_s && rd_rise && word_on) begin
               next_byte_phase = !byte_phase;
            end
            if (cs_n_s || rd_s) begin
               next_word_on = 1'b0;
            end
         end
         default: begin
            next_word_on = 1'b0;
         end
      endcase
      // Byte pairing restarts on each new frame
      if (cs_rise) begin
         next_byte_phase = 1'b0;
      end
   end

   // Dual serial lines
   always_comb begin
      next_shift_a        = shift_a;
      next_shift_b        = shift_b;
      next_serial_on      = serial_on;
      next_second_pending = second_pending;
      serial_pop          = 1'b0;

      if (cur_mode == mode_serial) begin
         if (cs_fall) begin
            // Two queued results go out side by side on A and B
            next_shift_a        = head_or_zero(q_valid, q_data);
            next_shift_b        = '0;
            serial_pop          = q_valid;
            next_second_pending = 1'b1;
            next_serial_on      = 1'b1;
         end else if (second_pending) begin
            next_shift_b        = head_or_zero(q_valid, q_data);
            serial_pop          = q_valid;
            next_second_pending = 1'b0;
         end else if (!cs_n_s && rd_rise && serial_on) begin
            next_shift_a = {shift_a[WIDTH-2:0], 1'b0};
            next_shift_b = {shift_b[WIDTH-2:0], 1'b0};
         end
         if (cs_n_s) begin
            next_serial_on = 1'b0;
         end
      end else begin
         next_serial_on = 1'b0;
      end
   end

   // Pin drive is built from the next state, so it moves with it
   always_comb begin
      next_bus_out = '0;
      next_bus_oe  = '0;
      case (cur_mode)
         mode_word: begin
            next_bus_out = next_out_word;
            next_bus_oe  = {WIDTH{next_word_on}};
         end
         mode_byte: begin
            // Upper byte first when high_byte_first, else lower first
            next_bus_out[BW-1:0] =
               pick_byte(next_out_word, high_first_s ^ next_byte_phase);
            next_bus_oe[BW-1:0]  = {BW{next_word_on}};
         end
         mode_serial: begin
            // Lines 6..0 and 13..9 stay undriven for the ground ties
            next_bus_out[`SERIAL_A_BIT] = next_shift_a[WIDTH-1];
            next_bus_out[`SERIAL_B_BIT] = next_shift_b[WIDTH-1];
            next_bus_oe[`SERIAL_A_BIT]  = next_serial_on;
            next_bus_oe[`SERIAL_B_BIT]  = next_serial_on;
         end
         default: begin
            next_bus_out = '0;
            next_bus_oe  = '0;
         end
      endcase
   end

   // Reset in mid-read zeroes the result registers
   always_ff @(posedge clk) begin
      if (rst) begin
         out_word   <= `RESULT_RESET;
         byte_phase <= 1'b0;
         word_on    <= 1'b0;
      end else begin
         out_word   <= next_out_word;
         byte_phase <= next_byte_phase;
         word_on    <= next_word_on;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         shift_a        <= `RESULT_RESET;
         shift_b        <= `RESULT_RESET;
         serial_on      <= 1'b0;
         second_pending <= 1'b0;
      end else begin
         shift_a        <= next_shift_a;
         shift_b        <= next_shift_b;
         serial_on      <= next_serial_on;
         second_pending <= next_second_pending;
      end
   end

   // Registered pins keep decode glitches off the shared lines
   always_ff @(posedge clk) begin
      if (rst) begin
         result_bus_out <= '0;
         result_bus_oe  <= '0;
      end else begin
         result_bus_out <= next_bus_out;
         result_bus_oe  <= next_bus_oe;
      end
   end

   // Reference enable and busy follow their inputs
   logic       next_ref_en, next_busy;
   logic [1:0] next_mode;
   always_comb begin
      next_ref_en = ref_s;
      next_busy   = conv_busy;
      next_mode   = cur_mode;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         internal_ref_enable <= 1'b0;
         busy                <= 1'b0;
         mode                <= 2'h0;
      end else begin
         internal_ref_enable <= next_ref_en;
         busy                <= next_busy;
         mode                <= next_mode;
      end
   end
endmodule

// [dv/result_port_chk.sv]
// Checker of result_port modes, lanes, reference and reset behaviour.
// Assumes a bind to result_port; straps change only with select high.
module result_port_chk #(
   parameter int WIDTH = 16
) (
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             interface_select,
   input wire logic             ref_select,
   input wire logic             internal_ref_enable,
   input wire logic             chip_select_n,
   input wire logic             read_n,
   input wire logic [WIDTH-1:0] result_bus_in,
   input wire logic [WIDTH-1:0] result_bus_out,
   input wire logic [WIDTH-1:0] result_bus_oe,
   input wire logic [1:0]       mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_reset_clears: assert property ($fell(rst) |->
      result_bus_oe == '0 && result_bus_out == '0)
      else $error("outputs not cleared by reset");
   chk_ref_follow: assert property ((ref_select [*4] |=>
      internal_ref_enable) and ((!ref_select) [*4] |=> !internal_ref_enable))
      else $error("reference enable does not follow select");
   chk_word_drive: assert property (
      (mode == 2'h0 && !chip_select_n && !read_n) [*6] |-> &result_bus_oe)
      else $error("word read not driven");
   chk_idle_quiet: assert property (
      (chip_select_n || (mode == 2'h0 && read_n)) [*5] |-> result_bus_oe == '0)
      else $error("lines driven outside a read");
   chk_mode_word: assert property (
      (!interface_select) [*5] |-> mode == 2'h0)
      else $error("word mode not entered");
   chk_mode_byte: assert property (
      (interface_select && result_bus_in[15]) [*5] |-> mode == 2'h1)
      else $error("byte mode not entered");
   chk_mode_serial: assert property (
      (interface_select && !result_bus_in[15]) [*5] |-> mode == 2'h2)
      else $error("serial mode not entered");
   chk_byte_lanes: assert property (
      mode == 2'h1 |-> result_bus_oe[WIDTH-1:8] == '0)
      else $error("byte mode drives upper lines");
   chk_serial_lanes: assert property (
      mode == 2'h2 |-> (result_bus_oe & 16'hfe7f) == 16'h0000)
      else $error("serial mode drives lines other than 7 and 8");
endmodule

bind result_port result_port_chk #(.WIDTH(WIDTH)) chk (.clk(clk), .rst(rst),
   .interface_select(interface_select), .ref_select(ref_select),
   .internal_ref_enable(internal_ref_enable), .read_n(read_n),
   .chip_select_n(chip_select_n), .result_bus_in(result_bus_in),
   .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe),
   .mode(mode));

// [dv/host_model.sv]
// Host on the result pins: straps, word, byte and serial reads.
// Assumes the bench calls its tasks; pins move 1 ns after a rising edge.
module host_model (
   input  wire logic        clk,
   input  wire logic [15:0] bus_out,
   input  wire logic [15:0] bus_oe,
   output logic             sel,
   output logic             cs_n,
   output logic             rd_n,
   output logic      [15:0] bus_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic        byte_sel = 1'b0;
   logic        high_first = 1'b0;
   logic [15:0] drv;
   // Floating lines show the inverse of the last value, never stale data; with sel high, lines 15..14 show the straps and 13..9, 6..0 read zero
   always_comb begin
      drv = ~bus_out;
      if (sel) begin
         drv[13:9] = 5'h00;
         drv[6:0] = 7'h00;
         drv[15] = byte_sel;
         drv[14] = high_first;
      end
   end
   assign bus_in = (bus_oe & bus_out) | (~bus_oe & drv);
   initial begin
      sel = 1'b0;
      cs_n = 1'b1;
      rd_n = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic hold(input logic c, r);
      cs_n = c;
      rd_n = r;
   endtask
   // Straps only move with chip select high, then settle
   task automatic cfg(input logic s, b, h);
      sel = s;
      byte_sel = b;
      high_first = h & b;
      wait_clk(8);
   endtask
   task automatic strobe(output logic [15:0] d);
      rd_n = 1'b0;
      wait_clk(6);
      d = bus_in;
      rd_n = 1'b1;
      wait_clk(6);
   endtask
   task automatic frame(input logic two, output logic [15:0] d0, d1);
      cs_n = 1'b0;
      strobe(d0);
      if (two) strobe(d1);
      cs_n = 1'b1;
      wait_clk(6);
   endtask
   // Serial clock idles high and only toggles inside a frame
   task automatic serial(output logic [15:0] a, b);
      cs_n = 1'b0;
      wait_clk(6);
      for (int i = 0; i < 16; i++) begin
         a = {a[14:0], bus_in[7]};
         b = {b[14:0], bus_in[8]};
         rd_n = 1'b0;
         wait_clk(5);
         rd_n = 1'b1;
         wait_clk(5);
      end
      cs_n = 1'b1;
      wait_clk(6);
   endtask
endmodule

// [dv/tb.sv]
// Self-checking bench of result_port with a host model on the pins.
// Assumes the design files and host_model.sv are compiled first.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {
      logic s, b, h;
      logic [15:0] w0, w1;
      logic [31:0] exp;
   } row_t;
   // Expected halves or bytes in the order the host receives them
   row_t rows[4] = '{'{0, 0, 0, 16'h8001, 16'h7ffe, 32'h8001_7ffe},
      '{1, 1, 1, 16'ha55a, 16'h1234, 32'ha55a_1234},
      '{1, 1, 0, 16'hc30f, 16'h00ff, 32'h0fc3_ff00},
      '{1, 0, 0, 16'h8000, 16'h0001, 32'h8000_0001}};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] conv_data = 16'h0000;
   logic        conv_valid = 1'b0;
   logic        conv_busy = 1'b0;
   logic        ref_select = 1'b0;
   logic        conv_ready, busy, internal_ref_enable, sel, cs_n, rd_n;
   logic [15:0] bus_in, bus_out, bus_oe, d0, d1;
   logic [15:0] q[$];
   logic [1:0]  mode;
   int          num_errors = 0;
   int          samples_checked = 0;
   result_port uut (.clk(clk), .rst(rst), .conv_data(conv_data),
      .conv_valid(conv_valid), .conv_ready(conv_ready),
      .conv_busy(conv_busy), .busy(busy), .interface_select(sel),
      .ref_select(ref_select), .internal_ref_enable(internal_ref_enable),
      .chip_select_n(cs_n), .read_n(rd_n), .result_bus_in(bus_in),
      .result_bus_out(bus_out), .result_bus_oe(bus_oe), .mode(mode));
   host_model host (.clk(clk), .bus_out(bus_out), .bus_oe(bus_oe),
      .sel(sel), .cs_n(cs_n), .rd_n(rd_n), .bus_in(bus_in));
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [15:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic push(input logic [15:0] w[$]);
      foreach (w[i]) begin
         conv_data = w[i];
         conv_valid = 1'b1;
         do @(posedge clk); while (conv_ready !== 1'b1);
         #1;
      end
      conv_valid = 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Several times the expected run, so only a hang reaches it
   initial begin
      #200000;
      num_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      host.wait_clk(4);
      check(bus_oe, 16'h0000);
      check({14'h0000, mode}, 16'h0000);
      $display("test reset done");
      foreach (rows[i]) begin
         host.cfg(rows[i].s, rows[i].b, rows[i].h);
         push('{rows[i].w0, rows[i].w1});
         if (rows[i].s && !rows[i].b) begin
            host.serial(d0, d1);
            check({d0}, rows[i].exp[31:16]);
            check({d1}, rows[i].exp[15:0]);
         end else begin
            for (int k = 0; k < 2; k++) begin
               host.frame(rows[i].b, d0, d1);
               check(rows[i].b ? {d0[7:0], d1[7:0]} : d0,
                  rows[i].exp[31-16*k -: 16]);
            end
         end
      end
      $display("test table done");
      host.cfg(1'b0, 1'b0, 1'b0);
      for (int i = 0; i < 16; i++) q.push_back(16'h0f00 + 16'(i));
      push(q);
      check({15'h0000, conv_ready}, 16'h0000);
      foreach (q[i]) begin
         host.frame(1'b0, d0, d1);
         check(d0, q[i]);
      end
      host.frame(1'b0, d0, d1);
      check(d0, 16'h0000);
      check({15'h0000, conv_ready}, 16'h0001);
      $display("test fill and drain done");
      push('{16'hbeef});
      host.hold(1'b0, 1'b0);
      host.wait_clk(6);
      check(bus_out, 16'hbeef);
      rst = 1'b1;
      host.wait_clk(1);
      check(bus_out, 16'h0000);
      check(bus_oe, 16'h0000);
      rst = 1'b0;
      host.hold(1'b1, 1'b1);
      host.wait_clk(2);
      check(bus_oe, 16'h0000);
      host.wait_clk(4);
      $display("test reset in read done");
      for (int v = 1; v >= 0; v--) begin
         ref_select = v[0];
         conv_busy = v[0];
         host.wait_clk(5);
         check({15'h0000, internal_ref_enable}, 16'(v));
         check({15'h0000, busy}, 16'(v));
      end
      $display("test reference done");
      tally_and_finish();
   end
endmodule
